// ### core/erc_core.sv
// Energy results, auxiliary RMS, configuration checksum, command reads.
// Assumes samples, cycle end and configuration words arrive on mclk.
`timescale 1ns/1ps
`default_nettype none
module erc_core
    import erc_pkg::*;
#(
    parameter int CFG_WORDS = CFG_WORDS_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Converter samples
    input wire logic sample_valid,
    input wire logic [PHASES-1:0][15:0] volt_sample,
    input wire logic [PHASES-1:0][15:0] curr_sample,
    input wire logic [PHASES-1:0][31:0] app_power_sample,
    input wire logic cycle_end,
    // RMS results from the arithmetic unit
    input wire logic aux_rms_valid,
    input wire logic [31:0] aux_rms_value,
    input wire logic [31:0] neutral_rms_current,
    // Covered configuration words, word 0 in the low bits
    input wire logic [CFG_WORDS*16-1:0] cfg_words,
    // Serial slave pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Results and commands
    output logic [PHASES-1:0][31:0] positive_real_energy_total,
    output logic [PHASES-1:0][31:0] negative_real_energy_total,
    output logic checksum_changed_flag,
    output logic push_mirror_to_hardware_cmd,
    output logic pull_hardware_to_mirror_cmd
);
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data_r, rd_data_nxt;
    logic rd_done_r;

    erc_spi_link u_link (
        .mclk(mclk),
        .reset_n(reset_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .miso(miso),
        .miso_oe(miso_oe),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data_r),
        .rd_done(rd_done_r)
    );

    // ****************************************************
    // Per-sample accumulation
    // ****************************************************
    logic signed [31:0] prod [PHASES];
    logic signed [ACC_W-1:0] real_acc_r [PHASES];
    logic signed [ACC_W-1:0] real_acc_nxt [PHASES];
    logic signed [ACC_W-1:0] app_acc_r [PHASES];
    logic signed [ACC_W-1:0] app_acc_nxt [PHASES];
    logic signed [31:0] real_slice [PHASES];
    logic signed [31:0] app_slice [PHASES];

    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            prod[p] = $signed(volt_sample[p]) * $signed(curr_sample[p]);
            // A sample landing on the cycle end opens the next cycle
            real_acc_nxt[p] = cycle_end ? '0 : real_acc_r[p];
            app_acc_nxt[p] = cycle_end ? '0 : app_acc_r[p];
            if (sample_valid) begin
                real_acc_nxt[p] = real_acc_nxt[p] + ACC_W'(prod[p]);
                app_acc_nxt[p] = app_acc_nxt[p]
                    + ACC_W'($signed(app_power_sample[p]));
            end
            real_slice[p] = real_acc_r[p][ENERGY_SHIFT +: 32];
            app_slice[p] = app_acc_r[p][ENERGY_SHIFT +: 32];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < PHASES; p++) begin
                real_acc_r[p] <= '0;
                app_acc_r[p] <= '0;
            end
        end else begin
            real_acc_r <= real_acc_nxt;
            app_acc_r <= app_acc_nxt;
        end
    end

    // ****************************************************
    // Cycle-end publishing
    // ****************************************************
    logic [31:0] real_r [PHASES];
    logic [31:0] real_nxt [PHASES];
    logic [31:0] app_r [PHASES];
    logic [31:0] app_nxt [PHASES];
    logic [31:0] pos_r [PHASES];
    logic [31:0] pos_nxt [PHASES];
    logic [31:0] neg_r [PHASES];
    logic [31:0] neg_nxt [PHASES];

    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            real_nxt[p] = real_r[p];
            app_nxt[p] = app_r[p];
            pos_nxt[p] = pos_r[p];
            neg_nxt[p] = neg_r[p];
            if (cycle_end) begin
                real_nxt[p] = real_slice[p];
                app_nxt[p] = app_slice[p];
                // Negative total keeps magnitude so it only grows
                if (!real_slice[p][31]) begin
                    pos_nxt[p] = pos_r[p] + real_slice[p];
                end else begin
                    neg_nxt[p] = neg_r[p] - real_slice[p];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < PHASES; p++) begin
                real_r[p] <= 32'h0000_0000;
                app_r[p] <= 32'h0000_0000;
                pos_r[p] <= 32'h0000_0000;
                neg_r[p] <= 32'h0000_0000;
            end
        end else begin
            real_r <= real_nxt;
            app_r <= app_nxt;
            pos_r <= pos_nxt;
            neg_r <= neg_nxt;
        end
    end

    always_comb begin
        for (int p = 0; p < PHASES; p++) begin
            positive_real_energy_total[p] = pos_r[p];
            negative_real_energy_total[p] = neg_r[p];
        end
    end

    // ****************************************************
    // RMS result holding
    // ****************************************************
    logic [31:0] aux_rms_r, aux_rms_nxt;
    logic [31:0] neut_rms_r;

    always_comb begin
        aux_rms_nxt = aux_rms_valid ? aux_rms_value : aux_rms_r;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aux_rms_r <= 32'h0000_0000;
            neut_rms_r <= 32'h0000_0000;
        end else begin
            aux_rms_r <= aux_rms_nxt;
            // Already in units picked by current_conversion_coefficient
            neut_rms_r <= neutral_rms_current;
        end
    end

    // ****************************************************
    // Configuration checksum
    // ****************************************************
    localparam int IDX_W = $clog2(CFG_WORDS);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(CFG_WORDS - 1);
    erc_ck_state_type ck_state_r, ck_state_nxt;
    logic [IDX_W-1:0] idx_r, idx_nxt;
    logic [15:0] sum_r, sum_nxt;
    logic [15:0] chk_r, chk_nxt;
    logic flag_r, flag_nxt;
    logic ck_done;
    logic [15:0] cur_word;
    logic chk_read;

    // Word walk costs one cycle per word but no adder tree
    always_comb begin
        cur_word = cfg_words[idx_r*16 +: 16];
        ck_state_nxt = ck_state_r;
        idx_nxt = idx_r;
        sum_nxt = sum_r;
        chk_nxt = chk_r;
        ck_done = 1'b0;
        unique case (ck_state_r)
            CK_IDLE: begin
            end
            CK_SUM: begin
                sum_nxt = sum_r + cur_word;
                idx_nxt = idx_r + 1'b1;
                if (idx_r == IDX_LAST) begin
                    ck_state_nxt = CK_IDLE;
                    chk_nxt = sum_nxt;
                    ck_done = 1'b1;
                end
            end
        endcase
        // Cycle end restarts an unfinished walk from the seed
        if (cycle_end) begin
            ck_state_nxt = CK_SUM;
            idx_nxt = '0;
            sum_nxt = CHK_SEED;
        end
        chk_read = rd_req && (rd_addr == ADDR_CONFIG_CHECKSUM);
        // Set beats the clear that a checksum read makes
        flag_nxt = chk_read ? 1'b0 : flag_r;
        if (ck_done && (chk_nxt != chk_r)) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ck_state_r <= CK_IDLE;
            idx_r <= '0;
            sum_r <= CHK_SEED;
            chk_r <= CHK_SEED;
            flag_r <= 1'b0;
        end else begin
            ck_state_r <= ck_state_nxt;
            idx_r <= idx_nxt;
            sum_r <= sum_nxt;
            chk_r <= chk_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign checksum_changed_flag = flag_r;

    // ****************************************************
    // Read decode and command triggers
    // ****************************************************
    logic push_r, push_nxt, pull_r, pull_nxt;

    always_comb begin
        rd_data_nxt = rd_data_r;
        push_nxt = 1'b0;
        pull_nxt = 1'b0;
        if (rd_req) begin
            case (rd_addr)
                ADDR_CONFIG_CHECKSUM: rd_data_nxt = {16'h0000, chk_r};
                ADDR_AUX_RMS: rd_data_nxt = aux_rms_r;
                ADDR_A_REAL: rd_data_nxt = real_r[0];
                ADDR_PHASE_A_CYCLE_APPARENT_ENERGY: rd_data_nxt = app_r[0];
                ADDR_B_REAL: rd_data_nxt = real_r[1];
                ADDR_PHASE_B_CYCLE_APPARENT_ENERGY: rd_data_nxt = app_r[1];
                ADDR_C_REAL: rd_data_nxt = real_r[2];
                ADDR_PHASE_C_CYCLE_APPARENT_ENERGY: rd_data_nxt = app_r[2];
                ADDR_NEUT_RMS: rd_data_nxt = neut_rms_r;
                ADDR_PUSH_CMD: begin
                    rd_data_nxt = DUMMY_DATA;
                    push_nxt = 1'b1;
                end
                ADDR_PULL_CMD: begin
                    rd_data_nxt = DUMMY_DATA;
                    pull_nxt = 1'b1;
                end
                default: rd_data_nxt = DUMMY_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= 32'h0000_0000;
            rd_done_r <= 1'b0;
            push_r <= 1'b0;
            pull_r <= 1'b0;
        end else begin
            rd_data_r <= rd_data_nxt;
            rd_done_r <= rd_req;
            push_r <= push_nxt;
            pull_r <= pull_nxt;
        end
    end

    assign push_mirror_to_hardware_cmd = push_r;
    assign pull_hardware_to_mirror_cmd = pull_r;

    // ****************************************************
    // Checks
    // ****************************************************
    localparam int SUM_BOUND = 300;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_acc_add_sample: assert property (
        !cycle_end && sample_valid |=> real_acc_r[0]
            == $past(real_acc_r[0]) + ACC_W'($past(prod[0])))
        else $error("real accumulator missed a sample");
    chk_acc_cycle_clear: assert property (
        cycle_end && !sample_valid |=> real_acc_r[0] == '0)
        else $error("real accumulator not cleared at cycle end");
    chk_real_publish: assert property (
        cycle_end |=> real_r[1] == $past(real_acc_r[1][ENERGY_SHIFT +: 32]))
        else $error("real energy not published");
    chk_app_publish: assert property (
        cycle_end |=> app_r[0] == $past(app_acc_r[0][ENERGY_SHIFT +: 32]))
        else $error("apparent energy not published");
    chk_pos_route: assert property (
        cycle_end && !real_slice[0][31] |=> pos_r[0]
            == $past(pos_r[0]) + $past(real_slice[0]) && $stable(neg_r[0]))
        else $error("positive energy misrouted");
    chk_neg_route: assert property (
        cycle_end && real_slice[1][31] |=> neg_r[1]
            == $past(neg_r[1]) - $past(real_slice[1]) && $stable(pos_r[1]))
        else $error("negative energy misrouted");
    chk_sum_refresh: assert property (
        cycle_end ##1 !cycle_end [*2] |-> ##[0:SUM_BOUND] ck_done || cycle_end)
        else $error("checksum not refreshed in time");
    chk_flag_on_change: assert property (
        $changed(chk_r) |-> checksum_changed_flag)
        else $error("checksum change did not set flag");
    chk_push_trigger: assert property (
        rd_req && rd_addr == ADDR_PUSH_CMD |=> push_mirror_to_hardware_cmd
            ##1 !push_mirror_to_hardware_cmd || $past(rd_req))
        else $error("push command not pulsed");
    chk_pull_trigger: assert property (
        rd_req && rd_addr == ADDR_PULL_CMD |=> pull_hardware_to_mirror_cmd
            && rd_data_r == DUMMY_DATA)
        else $error("pull command not pulsed with dummy data");
    chk_aux_hold: assert property (
        aux_rms_valid |=> aux_rms_r == $past(aux_rms_value))
        else $error("auxiliary RMS not captured");

    cov_neg_cycle: cover property (cycle_end && real_slice[1][31]);
    cov_flag_set: cover property ($rose(checksum_changed_flag));
    cov_push_cmd: cover property (push_mirror_to_hardware_cmd);
    cov_energy_read: cover property (rd_req && rd_addr == ADDR_A_REAL);
endmodule
`default_nettype wire

// ### core/erc_spi_link.sv
// Serial slave port: address header in, one 32-bit word out.
// Assumes sclk idles low, data sampled on rising, driven on falling edge.
`timescale 1ns/1ps
`default_nettype none
module erc_spi_link
    import erc_pkg::*;
(
    // Core clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Read request toward the core
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_done
);
    // ****************************************************
    // Link domain
    // ****************************************************
    // Frame logic ends with the frame itself; sclk may stop afterwards
    wire link_rst_n = reset_n & ~cs_n;
    logic [6:0] cnt_r, cnt_nxt;
    logic [15:0] sh_in_r, sh_in_nxt;
    logic req_tgl_r, req_tgl_nxt;
    logic [ADDR_W-1:0] addr_hold_r, addr_hold_nxt;
    logic ack_s1_r, ack_s2_r;
    logic [31:0] sh_out_r, sh_out_nxt;
    logic miso_r, miso_nxt;
    logic oe_r;
    logic ack_tgl_r;
    logic [31:0] data_hold_r;
    logic [31:0] load_word;

    always_comb begin
        cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 7'h01;
        sh_in_nxt = {sh_in_r[14:0], mosi};
        req_tgl_nxt = req_tgl_r;
        addr_hold_nxt = addr_hold_r;
        if (cnt_r == HDR_LAST) begin
            req_tgl_nxt = ~req_tgl_r;
            addr_hold_nxt = sh_in_nxt[ADDR_W-1:0];
        end
    end

    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_r <= 7'h00;
            sh_in_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
            sh_in_r <= sh_in_nxt;
        end
    end

    // Toggle and address must outlive the frame for the crossing
    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            req_tgl_r <= 1'b0;
            addr_hold_r <= 12'h000;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            req_tgl_r <= req_tgl_nxt;
            addr_hold_r <= addr_hold_nxt;
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    always_comb begin
        // Late core answer yields dummy data rather than a torn word
        load_word = (ack_s2_r == req_tgl_r) ? data_hold_r : DUMMY_DATA;
        sh_out_nxt = {sh_out_r[30:0], 1'b0};
        miso_nxt = sh_out_r[31];
        if (cnt_r == DATA_START) begin
            sh_out_nxt = {load_word[30:0], 1'b0};
            miso_nxt = load_word[31];
        end
    end

    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sh_out_r <= 32'h0000_0000;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            sh_out_r <= sh_out_nxt;
            miso_r <= miso_nxt;
            oe_r <= 1'b1;
        end
    end

    assign miso = miso_r;
    assign miso_oe = oe_r;

    // ****************************************************
    // Core domain
    // ****************************************************
    logic req_s1_r, req_s2_r, req_s3_r;
    logic rd_req_r, rd_req_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic ack_tgl_nxt;
    logic [31:0] data_hold_nxt;

    always_comb begin
        rd_req_nxt = req_s2_r ^ req_s3_r;
        rd_addr_nxt = rd_req_nxt ? addr_hold_r : rd_addr_r;
        ack_tgl_nxt = rd_done ? ~ack_tgl_r : ack_tgl_r;
        data_hold_nxt = rd_done ? rd_data : data_hold_r;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            rd_req_r <= 1'b0;
            rd_addr_r <= 12'h000;
            ack_tgl_r <= 1'b0;
            data_hold_r <= 32'h0000_0000;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            rd_req_r <= rd_req_nxt;
            rd_addr_r <= rd_addr_nxt;
            ack_tgl_r <= ack_tgl_nxt;
            data_hold_r <= data_hold_nxt;
        end
    end

    assign rd_req = rd_req_r;
    assign rd_addr = rd_addr_r;
endmodule
`default_nettype wire

// ### inc/erc_pkg.sv
// Constants shared by the energy result and checksum block.
// Assumes both design files import this package whole.
//
// Contract
// - Accumulate per-sample v*i real power per phase
// - Cycle end copies real energy to register
// - Cycle end adds energy to positive/negative total
// - Energy LSB is VFS*IFS*tFR over 2^16
// - Cycle end copies apparent energy to register
// - Hold auxiliary channel RMS in 32 bits
// - 16-bit checksum over critical configuration registers
// - Checksum recomputed once every processing cycle
// - Checksum value change sets changed flag
// - Neutral RMS current reported in its register
// - Reads of virtual addresses trigger commands
// - Push command read copies mirrors to hardware
// - Pull command read copies hardware to mirrors
package erc_pkg;
    // ****************************************************
    // Register map
    // ****************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CONFIG_CHECKSUM = 12'h060;
    localparam logic [11:0] ADDR_AUX_RMS = 12'h11c;
    localparam logic [11:0] ADDR_A_REAL = 12'h1d0;
    localparam logic [11:0] ADDR_PHASE_A_CYCLE_APPARENT_ENERGY = 12'h1d8;
    localparam logic [11:0] ADDR_B_REAL = 12'h2bc;
    localparam logic [11:0] ADDR_PHASE_B_CYCLE_APPARENT_ENERGY = 12'h2c4;
    localparam logic [11:0] ADDR_C_REAL = 12'h3a8;
    localparam logic [11:0] ADDR_PHASE_C_CYCLE_APPARENT_ENERGY = 12'h3b0;
    localparam logic [11:0] ADDR_NEUT_RMS = 12'h840;
    localparam logic [11:0] ADDR_PUSH_CMD = 12'h900;
    localparam logic [11:0] ADDR_PULL_CMD = 12'ha00;
    localparam logic [31:0] DUMMY_DATA = 32'h0000_0000;
    // ****************************************************
    // Arithmetic
    // ****************************************************
    localparam int PHASES = 3;
    localparam int ACC_W = 48;
    // Product of two full-scale samples is 2^30; LSB wants 2^16
    localparam int ENERGY_SHIFT = 14;
    localparam int CFG_WORDS_DEF = 54;
    localparam logic [15:0] CHK_SEED = 16'h0000;
    // ****************************************************
    // Serial frame: 16 address bits, 8 turnaround, 32 data
    // ****************************************************
    localparam logic [6:0] HDR_LAST = 7'h0f;
    localparam logic [6:0] DATA_START = 7'h18;
    localparam logic [6:0] CNT_MAX = 7'h7f;
    typedef enum {CK_IDLE, CK_SUM} erc_ck_state_type;
endpackage

// ### sim/energy_result_checksum_tb.sv
// Self-checking bench for the energy result and checksum block.
// Assumes erc_pkg is compiled first; the master model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module energy_result_checksum_tb;
    import erc_pkg::*;
    localparam int NW = 4;
    logic mclk, reset_n, sample_valid, cycle_end, aux_rms_valid;
    logic [2:0][15:0] volt_sample, curr_sample;
    logic [2:0][31:0] app_power_sample, pos_tot, neg_tot;
    logic [31:0] aux_rms_value, neutral_rms_current, rd;
    logic [NW*16-1:0] cfg_words;
    logic sclk, cs_n, mosi, miso, miso_oe, flag, push, pull;
    logic [31:0] push_cnt = 32'h0000_0000;
    logic [31:0] pull_cnt = 32'h0000_0000;
    int bad_count = 0;
    int tests_run = 0;

    erc_core #(.CFG_WORDS(NW)) DUT (.mclk(mclk), .reset_n(reset_n),
        .sample_valid(sample_valid), .volt_sample(volt_sample),
        .curr_sample(curr_sample), .app_power_sample(app_power_sample),
        .cycle_end(cycle_end), .aux_rms_valid(aux_rms_valid),
        .aux_rms_value(aux_rms_value), .neutral_rms_current(neutral_rms_current),
        .cfg_words(cfg_words), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .positive_real_energy_total(pos_tot),
        .negative_real_energy_total(neg_tot), .checksum_changed_flag(flag),
        .push_mirror_to_hardware_cmd(push), .pull_hardware_to_mirror_cmd(pull));
    erc_spi_master_model master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (push === 1'b1) push_cnt <= push_cnt + 1;
        if (pull === 1'b1) pull_cnt <= pull_cnt + 1;
    end

    // ****************************************************
    // Compare, access and stimulus tasks
    // ****************************************************
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic read_check(input logic [11:0] addr, input logic [31:0] exp);
        master.read_reg(addr, rd);
        check_word(rd, exp);
    endtask
    // Samples, then one cycle end, then wait out the checksum walk
    task automatic run_cycle(input int n);
        @(negedge mclk);
        repeat (n) begin
            sample_valid = 1'b1;
            @(negedge mclk);
        end
        sample_valid = 1'b0;
        cycle_end = 1'b1;
        @(negedge mclk);
        cycle_end = 1'b0;
        repeat (NW + 6) @(negedge mclk);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #300_000;
        bad_count++;
        complete_run();
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        reset_n = 1'b0;
        {sample_valid, cycle_end, aux_rms_valid} = 3'h0;
        aux_rms_value = 32'h0000_0000;
        neutral_rms_current = 32'h00ab_cdef;
        volt_sample = {16'h2000, 16'h4000, 16'h4000};
        curr_sample = {16'h4000, 16'hc000, 16'h4000};
        app_power_sample = {32'h0000_8000, 32'hffff_0000, 32'h0001_0000};
        // Sum wraps past 16 bits to 5
        cfg_words = {16'hffff, 16'h0003, 16'h0002, 16'h0001};
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        run_cycle(2);
        check_bit(flag, 1'b1);
        read_check(ADDR_A_REAL, 32'h0000_8000);
        read_check(ADDR_B_REAL, 32'hffff_8000);
        read_check(ADDR_C_REAL, 32'h0000_4000);
        read_check(ADDR_PHASE_A_CYCLE_APPARENT_ENERGY, 32'h0000_0008);
        read_check(ADDR_PHASE_B_CYCLE_APPARENT_ENERGY, 32'hffff_fff8);
        read_check(ADDR_PHASE_C_CYCLE_APPARENT_ENERGY, 32'h0000_0004);
        check_word(pos_tot[0], 32'h0000_8000);
        check_word(neg_tot[1], 32'h0000_8000);
        check_word(pos_tot[1], 32'h0000_0000);
        read_check(ADDR_CONFIG_CHECKSUM, 32'h0000_0005);
        check_bit(flag, 1'b0);
        run_cycle(2);
        check_bit(flag, 1'b0);
        check_word(pos_tot[0], 32'h0001_0000);
        check_word(neg_tot[1], 32'h0001_0000);
        read_check(ADDR_CONFIG_CHECKSUM, 32'h0000_0005);
        @(negedge mclk);
        cfg_words[15:0] = 16'h0002;
        run_cycle(0);
        read_check(ADDR_A_REAL, 32'h0000_0000);
        check_word(pos_tot[0], 32'h0001_0000);
        check_bit(flag, 1'b1);
        read_check(ADDR_CONFIG_CHECKSUM, 32'h0000_0006);
        @(negedge mclk);
        aux_rms_valid = 1'b1;
        aux_rms_value = 32'h1234_5678;
        @(negedge mclk);
        aux_rms_valid = 1'b0;
        aux_rms_value = 32'h0bad_0bad;
        read_check(ADDR_AUX_RMS, 32'h1234_5678);
        read_check(ADDR_NEUT_RMS, 32'h00ab_cdef);
        read_check(ADDR_PUSH_CMD, DUMMY_DATA);
        check_word(push_cnt, 32'h0000_0001);
        check_word(pull_cnt, 32'h0000_0000);
        read_check(ADDR_PULL_CMD, DUMMY_DATA);
        check_word(pull_cnt, 32'h0000_0001);
        check_word(push_cnt, 32'h0000_0001);
        read_check(12'h123, 32'h0000_0000);
        complete_run();
    end
endmodule
`default_nettype wire

// ### sim/erc_spi_master_model.sv
// Serial master model: one register read per frame, mode 0.
// Assumes the slave drives miso only while miso_oe is high.
`timescale 1ns/1ps
`default_nettype none
module erc_spi_master_model (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Clock stands low between frames; unused mosi bits toggle
    task automatic read_reg(input logic [11:0] addr, output logic [31:0] data);
        logic [15:0] hdr;
        hdr = {4'h0, addr};
        data = 32'h0000_0000;
        cs_n = 1'b0;
        for (int i = 0; i < 56; i++) begin
            mosi = (i < 16) ? hdr[15 - i] : ~mosi;
            #24 sclk = 1'b1;
            if (i >= 24) begin
                // Undriven line must not pass for data
                data = {data[30:0], miso_oe ? miso : 1'bx};
            end
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        #48;
    endtask
endmodule
`default_nettype wire
